// [dv/rac_periph_model.sv]
// switched peripheral behind the power control pin
`timescale 1ns/1ps
module rac_periph_model (
  // pin side
  input wire logic pin_level,
  input wire logic active_high,
  // supply state
  output logic powered
);
  // switch conducts only at the chosen active level
  assign powered = (pin_level === active_high);
endmodule

// [dv/rac_top_assertions.sv]
// checker for alarm sequencing and power pin relations
`timescale 1ns/1ps
module rac_chk #(
  parameter int CNT_W = 8
) (
  // clock, reset and stimulus seen
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic calendar_enable,
  input wire logic half_sec_tick,
  input wire rac_pkg::rac_pwc_cfg_t pwc_cfg,
  // outputs watched
  input wire logic [15:0] alarm_config_repeat_reg,
  input wire logic alarm_irq,
  input wire logic alarm_pulse,
  input wire logic power_ctrl_signal,
  input wire logic power_ctrl_oe,
  input wire logic sample_window_active
);
  logic en, indefinite_repeat, pen;
  logic [3:0] mask;
  logic [7:0] rpt;
  // configuration fields
  assign en = alarm_config_repeat_reg[15];
  assign indefinite_repeat = alarm_config_repeat_reg[14];
  assign mask = alarm_config_repeat_reg[13:10];
  assign rpt = alarm_config_repeat_reg[7:0];
  assign pen = pwc_cfg.enable;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_irq_one_cycle: assert property (alarm_irq |=> !alarm_irq)
    else $error("irq wider than one cycle");
  a_irq_cause: assert property (
    alarm_irq |-> $past(calendar_enable) && $past(half_sec_tick) && $past(en))
    else $error("irq without enabled tick");
  a_pulse_toggle: assert property (alarm_irq == (alarm_pulse != $past(alarm_pulse)))
    else $error("pulse not toggling with irq");
  a_count_step: assert property (
    alarm_irq && $past(rpt) != 8'h00 |-> rpt == $past(rpt) - 8'h01)
    else $error("repeat count not decremented");
  a_indefinite_repeat_wrap: assert property (
    alarm_irq && $past(rpt) == 8'h00 && $past(indefinite_repeat) |-> rpt == 8'hFF && en)
    else $error("indefinite_repeat wrap wrong");
  a_final_clear: assert property (
    alarm_irq && $past(rpt) == 8'h00 && !$past(indefinite_repeat) |-> !en && rpt == 8'h00)
    else $error("enable kept after final alarm");
  a_mask_legal: assert property (alarm_irq |-> $past(mask) <= 4'h9)
    else $error("irq from reserved mask");
  a_pin_enable: assert property (
    power_ctrl_oe == (pwc_cfg.pin_oe && pwc_cfg.pin_sel == rac_pkg::PIN_SEL_PWC))
    else $error("pin enable wrong");
  a_samp_always: assert property (pwc_cfg.samp == 8'hFF |-> sample_window_active)
    else $error("all-ones sample window closed");
  a_power_on: assert property (
    alarm_irq && pen && $past(pen) && pwc_cfg.stab != 8'h00 |->
    power_ctrl_signal == pwc_cfg.polarity) else $error("power not on at event");
  c_indefinite_repeat_wrap: cover property (alarm_irq && en && rpt == 8'hFF);
  c_final: cover property (alarm_irq && !en);
  c_sample: cover property ($rose(sample_window_active));
endmodule
bind rac_top rac_chk #(.CNT_W(CNT_W)) u_chk (.ref_clk(ref_clk), .srst(srst),
  .calendar_enable(calendar_enable), .half_sec_tick(half_sec_tick), .pwc_cfg(pwc_cfg),
  .alarm_config_repeat_reg(alarm_config_repeat_reg), .alarm_irq(alarm_irq),
  .alarm_pulse(alarm_pulse), .power_ctrl_signal(power_ctrl_signal),
  .power_ctrl_oe(power_ctrl_oe), .sample_window_active(sample_window_active));

// [dv/test_rac_top.sv]
// self-checking bench for the alarm and power-control block
`timescale 1ns/1ps
module test_rac_top;
  logic ref_clk, srst, calendar_enable, half_sec_tick, half_sec_phase, pwc_clk_tick;
  logic alarm_value_we, alarm_cfg_we, alarm_irq, alarm_pulse, pin_level, powered;
  logic power_ctrl_signal, power_ctrl_oe, sample_window_active;
  logic [15:0] alarm_cfg_wdata, alarm_config_repeat_reg;
  rac_pkg::rac_time_t now_time, alarm_value_wdata, alarm_value_regs, alm;
  rac_pkg::rac_pwc_cfg_t pwc_cfg;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int irq_seen = 0;
  int irq_exp = 0;
  rac_top #(.CNT_W(8)) u_dut (.ref_clk(ref_clk), .srst(srst),
    .calendar_enable(calendar_enable), .half_sec_tick(half_sec_tick),
    .half_sec_phase(half_sec_phase), .pwc_clk_tick(pwc_clk_tick), .now_time(now_time),
    .alarm_value_we(alarm_value_we), .alarm_value_wdata(alarm_value_wdata),
    .alarm_cfg_we(alarm_cfg_we), .alarm_cfg_wdata(alarm_cfg_wdata), .pwc_cfg(pwc_cfg),
    .alarm_config_repeat_reg(alarm_config_repeat_reg), .alarm_value_regs(alarm_value_regs),
    .alarm_irq(alarm_irq), .alarm_pulse(alarm_pulse), .power_ctrl_signal(power_ctrl_signal),
    .power_ctrl_oe(power_ctrl_oe), .sample_window_active(sample_window_active));
  // released pin floats to the pull-up
  assign pin_level = power_ctrl_oe ? power_ctrl_signal : 1'h1;
  rac_periph_model u_periph (.pin_level(pin_level), .active_high(pwc_cfg.polarity),
    .powered(powered));
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  // irq counting and hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (alarm_irq === 1'h1) irq_seen <= irq_seen + 1;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic cfg_wr(input logic [15:0] d);
    @(posedge ref_clk);
    alarm_cfg_we <= 1'h1;
    alarm_cfg_wdata <= d;
    @(posedge ref_clk);
    alarm_cfg_we <= 1'h0;
    wait_clk(1);
  endtask
  task automatic val_wr(input rac_pkg::rac_time_t t);
    @(posedge ref_clk);
    alarm_value_we <= 1'h1;
    alarm_value_wdata <= t;
    @(posedge ref_clk);
    alarm_value_we <= 1'h0;
    wait_clk(1);
    chk(16'(alarm_value_regs != t), 16'h0000);
  endtask
  // one half-second tick, then irq count and pulse parity
  task automatic half_tick(input logic ph, input logic fire);
    @(posedge ref_clk);
    half_sec_tick <= 1'h1;
    half_sec_phase <= ph;
    @(posedge ref_clk);
    half_sec_tick <= 1'h0;
    wait_clk(3);
    if (fire) irq_exp++;
    chk(16'(irq_seen), 16'(irq_exp));
    chk(16'(alarm_pulse), 16'(irq_exp % 2));
  endtask
  task automatic pwc_ticks(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      pwc_clk_tick <= 1'h1;
      @(posedge ref_clk);
      pwc_clk_tick <= 1'h0;
    end
    wait_clk(2);
  endtask
  initial begin
    srst = 1'h1;
    calendar_enable = 1'h1;
    {half_sec_tick, half_sec_phase, pwc_clk_tick, alarm_value_we, alarm_cfg_we} = '0;
    alarm_cfg_wdata = 16'h0000;
    alm = '{5'h03, 6'h15, 3'h2, 6'h12, 7'h34, 7'h56};
    now_time = alm;
    alarm_value_wdata = alm;
    pwc_cfg = '{1'h0, 1'h1, 8'h00, 8'h00, 1'h1, 2'h3};
    repeat (16) @(posedge ref_clk);
    srst <= 1'h0;
    wait_clk(1);
    chk(alarm_config_repeat_reg, 16'h0000);
    chk(16'({power_ctrl_signal, power_ctrl_oe}), 16'h0001);
    val_wr(alm);
    // every code with all digits equal; codes 0..9 fire and indefinite_repeat wraps the count, 10..15 stay silent
    for (int m = 0; m < 16; m++) begin
      cfg_wr({2'h3, 4'(m), 10'h000});
      half_tick(1'h0, m < 10);
      chk(alarm_config_repeat_reg, {2'h3, 4'(m), (m < 10) ? 10'h0FF : 10'h000});
    end
    // seconds ones digit differs
    now_time.second <= 7'h57;
    for (int m = 0; m < 10; m++) begin
      cfg_wr({2'h3, 4'(m), 10'h000});
      half_tick(1'h0, m < 2);
    end
    // second half of a second
    for (int m = 0; m < 2; m++) begin
      cfg_wr({2'h3, 4'(m), 10'h000});
      half_tick(1'h1, m == 0);
    end
    calendar_enable <= 1'h0;
    half_tick(1'h0, 1'h0);
    calendar_enable <= 1'h1;
    // leap-day yearly setting stays silent
    cfg_wr(16'h0000);
    alm.month = 5'h02;
    alm.day = 6'h29;
    val_wr(alm);
    now_time <= alm;
    cfg_wr(16'hA400);
    half_tick(1'h0, 1'h0);
    // counted repeats down to the final alarm
    cfg_wr(16'h8002);
    for (int i = 2; i > 0; i--) begin
      half_tick(1'h0, 1'h1);
      chk(alarm_config_repeat_reg, 16'(16'h8000 + i - 1));
    end
    half_tick(1'h0, 1'h1);
    chk(alarm_config_repeat_reg, 16'h0000);
    half_tick(1'h0, 1'h0);
    cfg_wr(16'h80FF);
    half_tick(1'h0, 1'h1);
    chk(alarm_config_repeat_reg, 16'h80FE);
    // stability then sample window, both polarities
    for (int p = 0; p < 2; p++) begin
      pwc_cfg <= '{1'h1, 1'(p), 8'h03, 8'h02, 1'h1, 2'h3};
      cfg_wr(16'hC000);
      half_tick(1'h0, 1'h1);
      chk(16'({sample_window_active, powered}), 16'h0001);
      pwc_ticks(2);
      chk(16'({sample_window_active, powered}), 16'h0001);
      pwc_ticks(1);
      chk(16'({sample_window_active, powered}), 16'h0003);
      pwc_ticks(1);
      chk(16'({sample_window_active, powered}), 16'h0003);
      pwc_ticks(1);
      chk(16'({sample_window_active, powered}), 16'h0000);
    end
    // no stability window: sampling opens at the event
    pwc_cfg <= '{1'h1, 1'h1, 8'h00, 8'h01, 1'h1, 2'h3};
    half_tick(1'h0, 1'h1);
    chk(16'({sample_window_active, powered}), 16'h0003);
    pwc_ticks(1);
    chk(16'(sample_window_active), 16'h0000);
    // all-ones sample window with power control off
    pwc_cfg <= '{1'h0, 1'h1, 8'h00, 8'hFF, 1'h0, 2'h3};
    wait_clk(1);
    chk(16'({sample_window_active, power_ctrl_oe}), 16'h0002);
    give_verdict();
  end
endmodule

// [rtl/rac_match.sv]
// alarm digit comparator under the mask code
`timescale 1ns/1ps
module rac_match (
  // calendar
  input wire rac_pkg::rac_time_t now,
  input wire logic half_sec,
  // alarm setting
  input wire rac_pkg::rac_time_t alm,
  input wire logic [3:0] mask,
  // result
  output logic hit
);
  logic s1, s10, m1, m10, h, d, wd, mo, feb29;

  // per-digit equality
  always_comb begin
    s1 = now.second[3:0] == alm.second[3:0];
    s10 = now.second[6:4] == alm.second[6:4];
    m1 = now.minute[3:0] == alm.minute[3:0];
    m10 = now.minute[6:4] == alm.minute[6:4];
    h = now.hour == alm.hour;
    d = now.day == alm.day;
    wd = now.weekday == alm.weekday;
    mo = now.month == alm.month;
    feb29 = (alm.month == rac_pkg::FEB_MONTH) && (alm.day == rac_pkg::FEB_29_DAY);
  end

  // digit set chosen by mask, first half-second only for periods of a second or more
  always_comb begin
    case (mask)
      rac_pkg::MASK_HALF_SEC: hit = 1'b1;
      rac_pkg::MASK_SEC: hit = ~half_sec;
      rac_pkg::MASK_TEN_SEC: hit = ~half_sec & s1;
      rac_pkg::MASK_MIN: hit = ~half_sec & s1 & s10;
      rac_pkg::MASK_TEN_MIN: hit = ~half_sec & s1 & s10 & m1;
      rac_pkg::MASK_HOUR: hit = ~half_sec & s1 & s10 & m1 & m10;
      rac_pkg::MASK_DAY: hit = ~half_sec & s1 & s10 & m1 & m10 & h;
      rac_pkg::MASK_WEEK: hit = ~half_sec & s1 & s10 & m1 & m10 & h & wd;
      rac_pkg::MASK_MONTH: hit = ~half_sec & s1 & s10 & m1 & m10 & h & d;
      rac_pkg::MASK_YEAR: hit = ~half_sec & s1 & s10 & m1 & m10 & h & d & mo & ~feb29;
      default: hit = 1'b0;
    endcase
  end
endmodule

// [rtl/rac_pkg.sv]
// package: constants and types for the alarm and power-control block
// Contract
// - alarm matching runs only while alarm_enable is set; hardware clears it on final alarm
// - four-bit alarm_mask at bits 13:10 selects which calendar digits must match
// - mask codes 0000..1000 give half-second, second, ... up to monthly alarms
// - repeat_count at bits 7:0; 00h with indefinite_repeat clear gives exactly one alarm
// - repeat_count FFh allows up to 255 additional alarms
// - each issued alarm except the final one decrements repeat_count by one; the final alarm of a counted run leaves it at 00h
// - at 00h without indefinite_repeat, last alarm issues then alarm_enable clears
// - with indefinite_repeat set, count wraps 00h to FFh and alarm stays enabled
// - every alarm event raises an alarm interrupt request
// - alarm pulse output toggles on each alarm event, synchronous to clock
// - power control autonomously powers device, waits stability, samples, powers off
// - power_ctrl_polarity selects active-high or active-low output
// - eight-bit stability window 1..255 periods; zero means sample at alarm event
// - eight-bit sample window 1..254 periods; zero none; all ones always sampling
// - sample window starts when stability timer expires, unless stability is zero
package rac_pkg;
  // alarm configuration register field positions
  localparam int ALM_EN_BIT = 15;
  localparam int ALM_INDEFINITE_REPEAT_BIT = 14;
  localparam int ALM_MASK_HI = 13;
  localparam int ALM_MASK_LO = 10;
  localparam int ALM_RPT_HI = 7;
  localparam int ALM_RPT_LO = 0;
  // power control register field positions
  localparam int PWC_EN_BIT = 15;
  localparam int PWC_POL_BIT = 14;
  localparam int PWC_STAB_HI = 15;
  localparam int PWC_STAB_LO = 8;
  localparam int PWC_SAMP_HI = 7;
  localparam int PWC_SAMP_LO = 0;
  // reset values, all-ones count and pin-select code
  localparam logic [15:0] ALM_CFG_RST = 16'h0000;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_FULL = 8'hFF;
  localparam logic [1:0] PIN_SEL_PWC = 2'h3;
  // mask codes
  localparam logic [3:0] MASK_HALF_SEC = 4'h0;
  localparam logic [3:0] MASK_SEC = 4'h1;
  localparam logic [3:0] MASK_TEN_SEC = 4'h2;
  localparam logic [3:0] MASK_MIN = 4'h3;
  localparam logic [3:0] MASK_TEN_MIN = 4'h4;
  localparam logic [3:0] MASK_HOUR = 4'h5;
  localparam logic [3:0] MASK_DAY = 4'h6;
  localparam logic [3:0] MASK_WEEK = 4'h7;
  localparam logic [3:0] MASK_MONTH = 4'h8;
  localparam logic [3:0] MASK_YEAR = 4'h9;
  localparam logic [5:0] FEB_29_DAY = 6'h29;
  localparam logic [4:0] FEB_MONTH = 5'h02;

  // calendar digits in bcd
  typedef struct packed {
    logic [4:0] month;
    logic [5:0] day;
    logic [2:0] weekday;
    logic [5:0] hour;
    logic [6:0] minute;
    logic [6:0] second;
  } rac_time_t;

  // power control settings
  typedef struct packed {
    logic enable;
    logic polarity;
    logic [7:0] stab;
    logic [7:0] samp;
    logic pin_oe;
    logic [1:0] pin_sel;
  } rac_pwc_cfg_t;

  // power control sequencer states
  typedef enum logic [2:0] {
    PWC_IDLE = 3'b001,
    PWC_STAB = 3'b010,
    PWC_SAMP = 3'b100
  } rac_pwc_state_t;
endpackage

// [rtl/rac_top.sv]
// alarm sequencing and power-control timing for the clock-calendar
`timescale 1ns/1ps
module rac_top #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // timekeeping inputs
  input wire logic calendar_enable,
  input wire logic half_sec_tick,
  input wire logic half_sec_phase,
  input wire logic pwc_clk_tick,
  input wire rac_pkg::rac_time_t now_time,
  // alarm value writes
  input wire logic alarm_value_we,
  input wire rac_pkg::rac_time_t alarm_value_wdata,
  // alarm configuration writes
  input wire logic alarm_cfg_we,
  input wire logic [15:0] alarm_cfg_wdata,
  // power control configuration
  input wire rac_pkg::rac_pwc_cfg_t pwc_cfg,
  // status
  output logic [15:0] alarm_config_repeat_reg,
  output rac_pkg::rac_time_t alarm_value_regs,
  output logic alarm_irq,
  output logic alarm_pulse,
  // power control pin
  output logic power_ctrl_signal,
  output logic power_ctrl_oe,
  output logic sample_window_active
);
  logic alarm_enable_q;
  logic indefinite_repeat_q;
  logic [3:0] alarm_mask_q;
  logic [CNT_W-1:0] repeat_count_q;
  rac_pkg::rac_time_t alm_val_q;
  logic hit;
  logic alarm_event;
  logic irq_q, pulse_q;
  rac_pkg::rac_pwc_state_t state_q;
  logic [7:0] pwc_cnt_q;
  logic pwc_active;
  logic pwc_on;
  logic final_alarm;
  logic stab_set, samp_set;

  // nonzero window field means the window is in use
  function automatic logic win_set(input logic [7:0] w);
    return w != rac_pkg::CNT_ZERO;
  endfunction

  rac_match u_match (
    .now(now_time),
    .half_sec(half_sec_phase),
    .alm(alm_val_q),
    .mask(alarm_mask_q),
    .hit(hit)
  );

  // one event per matching half-second tick
  assign alarm_event = calendar_enable & alarm_enable_q & half_sec_tick & hit;

  // last alarm of a counted run, nothing to wrap into
  assign final_alarm = alarm_event & (repeat_count_q == CNT_W'(0)) &
                       ~indefinite_repeat_q;

  // window field decode shared by the sequencer branches
  assign stab_set = win_set(pwc_cfg.stab);
  assign samp_set = win_set(pwc_cfg.samp);

  // alarm value storage, written by software while disabled
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      alm_val_q <= '0;
    end else if (alarm_value_we) begin
      alm_val_q <= alarm_value_wdata;
    end
  end

  // enable, indefinite_repeat and mask; hardware clear of enable beats software write
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      alarm_enable_q <= rac_pkg::ALM_CFG_RST[rac_pkg::ALM_EN_BIT];
      indefinite_repeat_q <= rac_pkg::ALM_CFG_RST[rac_pkg::ALM_INDEFINITE_REPEAT_BIT];
      alarm_mask_q <= rac_pkg::ALM_CFG_RST[rac_pkg::ALM_MASK_HI:rac_pkg::ALM_MASK_LO];
    end else begin
      if (alarm_cfg_we) begin
        alarm_enable_q <= alarm_cfg_wdata[rac_pkg::ALM_EN_BIT];
        indefinite_repeat_q <= alarm_cfg_wdata[rac_pkg::ALM_INDEFINITE_REPEAT_BIT];
        alarm_mask_q <= alarm_cfg_wdata[rac_pkg::ALM_MASK_HI:rac_pkg::ALM_MASK_LO];
      end
      if (final_alarm) begin
        alarm_enable_q <= 1'b0;
      end
    end
  end

  // repeat counter, decremented per alarm, wraps when chiming
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      repeat_count_q <= CNT_W'(0);
    end else if (alarm_event) begin
      // a finished run holds at zero instead of wrapping
      if (!final_alarm) begin
        repeat_count_q <= repeat_count_q - CNT_W'(1);
      end
    end else if (alarm_cfg_we) begin
      repeat_count_q <= alarm_cfg_wdata[CNT_W-1:0];
    end
  end

  // interrupt request pulse and half-rate alarm output
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      irq_q <= alarm_event;
      if (alarm_event) begin
        pulse_q <= ~pulse_q;
      end
    end
  end

  // power-control sequencer: stability window then sample window
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= rac_pkg::PWC_IDLE;
      pwc_cnt_q <= rac_pkg::CNT_ZERO;
    end else if (!pwc_cfg.enable) begin
      state_q <= rac_pkg::PWC_IDLE;
      pwc_cnt_q <= rac_pkg::CNT_ZERO;
    end else begin
      case (state_q)
        rac_pkg::PWC_IDLE: begin
          if (alarm_event) begin
            if (stab_set) begin
              state_q <= rac_pkg::PWC_STAB;
              pwc_cnt_q <= pwc_cfg.stab;
            end else if (samp_set) begin
              state_q <= rac_pkg::PWC_SAMP;
              pwc_cnt_q <= pwc_cfg.samp;
            end
          end
        end
        rac_pkg::PWC_STAB: begin
          if (pwc_clk_tick) begin
            if (pwc_cnt_q == 8'h01) begin
              if (samp_set) begin
                state_q <= rac_pkg::PWC_SAMP;
                pwc_cnt_q <= pwc_cfg.samp;
              end else begin
                state_q <= rac_pkg::PWC_IDLE;
                pwc_cnt_q <= rac_pkg::CNT_ZERO;
              end
            end else begin
              pwc_cnt_q <= pwc_cnt_q - 8'h01;
            end
          end
        end
        rac_pkg::PWC_SAMP: begin
          if (pwc_clk_tick && pwc_cfg.samp != rac_pkg::CNT_FULL) begin
            if (pwc_cnt_q == 8'h01) begin
              state_q <= rac_pkg::PWC_IDLE;
              pwc_cnt_q <= rac_pkg::CNT_ZERO;
            end else begin
              pwc_cnt_q <= pwc_cnt_q - 8'h01;
            end
          end
        end
        default: begin
          state_q <= rac_pkg::PWC_IDLE;
          pwc_cnt_q <= rac_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  // output pin drive with polarity
  assign pwc_active = state_q != rac_pkg::PWC_IDLE;
  assign pwc_on = pwc_cfg.enable & pwc_active;
  assign sample_window_active = (state_q == rac_pkg::PWC_SAMP) |
                                (pwc_cfg.samp == rac_pkg::CNT_FULL);
  assign power_ctrl_signal = pwc_cfg.polarity ? pwc_on : ~pwc_on;
  assign power_ctrl_oe = pwc_cfg.pin_oe & (pwc_cfg.pin_sel == rac_pkg::PIN_SEL_PWC);

  // status views
  assign alarm_config_repeat_reg = {alarm_enable_q, indefinite_repeat_q, alarm_mask_q,
                                    2'h0, repeat_count_q};
  assign alarm_value_regs = alm_val_q;
  assign alarm_irq = irq_q;
  assign alarm_pulse = pulse_q;
endmodule
